/* ecs_map.vh */
// address ranges, fixed counts and report column layout for the fill and step control
`ifndef ECS_MAP_VH
`define ECS_MAP_VH

// ----------------------------------------
// data memory area per chip mode
// ----------------------------------------
`define ECS_DM_LO_SMALL    12'h0780
`define ECS_DM_LO_LARGE    12'h0700
`define ECS_DM_HI          12'h07FF

// ----------------------------------------
// program start address limits
// ----------------------------------------
`define ECS_PC_LO          12'h0000
`define ECS_PC_HI_SMALL    12'h07DF
`define ECS_PC_HI_LARGE    12'h0FDF

// ----------------------------------------
// step counts
// ----------------------------------------
`define ECS_STEP_MAX       16'hFFFF
`define ECS_STEP_ONE       16'h0001
`define ECS_HDR_EVERY      4'hA

// ----------------------------------------
// report columns: b a h l x y c p0 p1 p2 p3 p4 sp
// ----------------------------------------
`define ECS_NCOLS          13
`define ECS_COL_W          8
`define ECS_COL_PORT4      11
`define ECS_COLS_ALL       13'h1FFF

`endif

/* ecs_range_chk.v */
// inclusive range check of an address against a lower and upper bound
`timescale 1ns/10ps

module ecs_range_chk #(
	parameter W = 12
) (
	// value and bounds
	input  wire [W-1:0] i_val,
	input  wire [W-1:0] i_lo,
	input  wire [W-1:0] i_hi,
	// result
	output wire         o_ok
);

	assign o_ok = (i_val >= i_lo) && (i_val <= i_hi);

endmodule // ecs_range_chk

/* ecs_snap_cmp.v */
// holds the previous register and port snapshot and flags which columns changed
`timescale 1ns/10ps

module ecs_snap_cmp #(
	parameter NCOLS = 13,
	parameter CW    = 8
) (
	// clock and reset
	input  wire                  i_clk,
	input  wire                  i_srst,
	// snapshot
	input  wire [NCOLS*CW-1:0]   i_cur,
	input  wire                  i_load,
	input  wire                  i_force,
	// result
	output wire [NCOLS-1:0]      o_show
);

	reg [NCOLS*CW-1:0] prev_reg;

	always @(posedge i_clk) begin
		if (i_srst) begin
			prev_reg <= {NCOLS*CW{1'b0}};
		end else if (i_load) begin
			prev_reg <= i_cur;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCOLS; g = g + 1) begin : g_col
			// a number where changed, or everything right after a header
			assign o_show[g] = i_force | (i_cur[g*CW +: CW] != prev_reg[g*CW +: CW]);
		end
	endgenerate

endmodule // ecs_snap_cmp

/* ecs_fill_step_ctl.v */
// command engine for data memory fill and single stepping of the emulated core
//
// Contract
// - two addresses: write the nibble, or zero, from first through second
// - wildcard: write the nibble, or zero, over the whole mode data area
// - no start address: stepping starts at the current program counter
// - wildcard step: 65535 steps from the current program counter
// - omitted count executes exactly one instruction
// - halt after each instruction, report address, code, then registers and ports
// - a met skip is passed within the same step and not reported
// - abort key ends an ongoing step command
// - abort key is ignored while the core is in halt mode
// - header of thirteen columns repeats every 10 steps
// - unchanged values show as a dot, changed ones as a number
// - first line after each header shows every value
// - small mode drops the port four column
// - add immediate skip may skip when run as an isolated step
// - time base counter is kept across single steps
// - timers are only assured on the internal clock while stepping
`timescale 1ns/10ps
`include "ecs_map.vh"

module ecs_fill_step_ctl #(
	parameter AW = 12,
	parameter DW = 4,
	parameter CNTW = 16,
	parameter IW = 16
) (
	// clock and reset
	input  wire                             i_clk,
	input  wire                             i_srst,
	// chip mode: 1 large, 0 small
	input  wire                             i_large_mode,
	// command request
	input  wire                             i_cmd_valid,
	input  wire                             i_cmd_fill,
	input  wire                             i_cmd_step,
	input  wire                             i_cmd_wild,
	input  wire                             i_cmd_addr_given,
	input  wire [AW-1:0]                    i_cmd_addr_a,
	input  wire [AW-1:0]                    i_cmd_addr_b,
	input  wire                             i_cmd_data_given,
	input  wire [DW-1:0]                    i_cmd_data,
	input  wire                             i_cmd_count_given,
	input  wire [CNTW-1:0]                  i_cmd_count,
	input  wire                             i_abort_key,
	// command answer
	output reg                              o_busy,
	output reg                              o_cmd_done,
	output reg                              o_cmd_err,
	output reg                              o_cmd_aborted,
	// data memory write port
	output reg                              o_mem_we,
	output reg  [AW-1:0]                    o_mem_addr,
	output reg  [DW-1:0]                    o_mem_wdata,
	// core step control
	output reg                              o_core_step,
	output reg                              o_core_set_pc,
	output reg  [AW-1:0]                    o_core_pc,
	output reg                              o_core_solo_skip_en,
	input  wire                             i_core_done,
	input  wire                             i_core_halt,
	input  wire [AW-1:0]                    i_core_exec_addr,
	input  wire [IW-1:0]                    i_core_exec_code,
	input  wire [`ECS_NCOLS*`ECS_COL_W-1:0] i_core_snap,
	// step report
	output reg                              o_rep_valid,
	output reg                              o_rep_hdr,
	output reg  [AW-1:0]                    o_rep_addr,
	output reg  [IW-1:0]                    o_rep_code,
	output reg  [`ECS_NCOLS-1:0]            o_rep_cols,
	output reg  [`ECS_NCOLS-1:0]            o_rep_show,
	output reg  [`ECS_NCOLS*`ECS_COL_W-1:0] o_rep_vals
);

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_FILL = 2'd1;
	localparam [1:0] ST_REQ  = 2'd2;
	localparam [1:0] ST_WAIT = 2'd3;

	reg [1:0]      state_reg;
	reg [AW-1:0]   addr_reg;
	reg [AW-1:0]   end_reg;
	reg [DW-1:0]   data_reg;
	reg [CNTW-1:0] left_reg;
	reg [3:0]      hdr_cnt_reg;
	reg            abort_reg;

	// ----------------------------------------
	// range checks
	// ----------------------------------------
	wire [AW-1:0] dm_lo = i_large_mode ? `ECS_DM_LO_LARGE : `ECS_DM_LO_SMALL;
	wire [AW-1:0] pc_hi = i_large_mode ? `ECS_PC_HI_LARGE : `ECS_PC_HI_SMALL;
	wire          ok_a;
	wire          ok_b;
	wire          ok_pc;

	ecs_range_chk #(.W(AW)) u_chk_a (
		.i_val (i_cmd_addr_a),
		.i_lo  (dm_lo),
		.i_hi  (`ECS_DM_HI),
		.o_ok  (ok_a)
	);

	ecs_range_chk #(.W(AW)) u_chk_b (
		.i_val (i_cmd_addr_b),
		.i_lo  (dm_lo),
		.i_hi  (`ECS_DM_HI),
		.o_ok  (ok_b)
	);

	ecs_range_chk #(.W(AW)) u_chk_pc (
		.i_val (i_cmd_addr_a),
		.i_lo  (`ECS_PC_LO),
		.i_hi  (pc_hi),
		.o_ok  (ok_pc)
	);

	// a reversed pair is refused too: nothing sensible to fill
	wire fill_ok = i_cmd_wild | (ok_a & ok_b & (i_cmd_addr_a <= i_cmd_addr_b));
	// the wildcard takes precedence over any address given with it
	wire use_addr = i_cmd_addr_given & ~i_cmd_wild;
	wire step_ok = (~use_addr | ok_pc) &
	               (i_cmd_wild | ~i_cmd_count_given | (i_cmd_count != {CNTW{1'b0}}));

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// fill wins when both commands are flagged at once
	wire           fill_req = i_cmd_valid & i_cmd_fill;
	wire           step_req = i_cmd_valid & i_cmd_step & ~i_cmd_fill;
	reg [AW-1:0]   fill_lo_next;
	reg [AW-1:0]   fill_hi_next;
	reg [DW-1:0]   fill_data_next;
	reg [CNTW-1:0] steps_next;

	always @* begin
		fill_lo_next   = i_cmd_addr_a;
		fill_hi_next   = i_cmd_addr_b;
		fill_data_next = {DW{1'b0}};
		steps_next     = `ECS_STEP_ONE;
		if (i_cmd_wild) begin
			fill_lo_next = dm_lo;
			fill_hi_next = `ECS_DM_HI;
		end
		// missing value fills with zero; the value is a nibble by width
		if (i_cmd_data_given) begin
			fill_data_next = i_cmd_data;
		end
		// a wildcard overrides any count given alongside it
		if (i_cmd_wild) begin
			steps_next = `ECS_STEP_MAX;
		end else if (i_cmd_count_given) begin
			steps_next = i_cmd_count;
		end
	end

	// ----------------------------------------
	// change detection for the report
	// ----------------------------------------
	wire                  hdr_due = (hdr_cnt_reg == 4'h0);
	wire                  snap_load = (state_reg == ST_WAIT) & i_core_done;
	wire [`ECS_NCOLS-1:0] show;

	ecs_snap_cmp #(.NCOLS(`ECS_NCOLS), .CW(`ECS_COL_W)) u_cmp (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_cur   (i_core_snap),
		.i_load  (snap_load),
		.i_force (hdr_due),
		.o_show  (show)
	);

	// port four column only exists in large mode
	wire [`ECS_NCOLS-1:0] cols = i_large_mode ? `ECS_COLS_ALL :
	                             (`ECS_COLS_ALL & ~(13'h0001 << `ECS_COL_PORT4));

	// halt mode swallows the key, it is not remembered for later
	wire abort_hit = i_abort_key & ~i_core_halt;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (i_srst) begin
			state_reg           <= ST_IDLE;
			addr_reg            <= {AW{1'b0}};
			end_reg             <= {AW{1'b0}};
			data_reg            <= {DW{1'b0}};
			left_reg            <= {CNTW{1'b0}};
			hdr_cnt_reg         <= 4'h0;
			abort_reg           <= 1'b0;
			o_busy              <= 1'b0;
			o_cmd_done          <= 1'b0;
			o_cmd_err           <= 1'b0;
			o_cmd_aborted       <= 1'b0;
			o_mem_we            <= 1'b0;
			o_mem_addr          <= {AW{1'b0}};
			o_mem_wdata         <= {DW{1'b0}};
			o_core_step         <= 1'b0;
			o_core_set_pc       <= 1'b0;
			o_core_pc           <= {AW{1'b0}};
			o_core_solo_skip_en <= 1'b0;
			o_rep_valid         <= 1'b0;
			o_rep_hdr           <= 1'b0;
			o_rep_addr          <= {AW{1'b0}};
			o_rep_code          <= {IW{1'b0}};
			o_rep_cols          <= {`ECS_NCOLS{1'b0}};
			o_rep_show          <= {`ECS_NCOLS{1'b0}};
			o_rep_vals          <= {`ECS_NCOLS*`ECS_COL_W{1'b0}};
		end else begin
			o_cmd_done    <= 1'b0;
			o_cmd_err     <= 1'b0;
			o_cmd_aborted <= 1'b0;
			o_mem_we      <= 1'b0;
			o_core_step   <= 1'b0;
			o_core_set_pc <= 1'b0;
			o_rep_valid   <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					abort_reg <= 1'b0;
					if (fill_req) begin
						if (fill_ok) begin
							addr_reg  <= fill_lo_next;
							end_reg   <= fill_hi_next;
							data_reg  <= fill_data_next;
							o_busy    <= 1'b1;
							state_reg <= ST_FILL;
						end else begin
							o_cmd_err <= 1'b1;
						end
					end else if (step_req) begin
						if (step_ok) begin
							left_reg <= steps_next;
							// without a start address the core keeps its own pc
							o_core_set_pc       <= use_addr;
							o_core_pc           <= i_cmd_addr_a;
							o_core_solo_skip_en <= 1'b1;
							hdr_cnt_reg         <= 4'h0;
							o_busy              <= 1'b1;
							state_reg           <= ST_REQ;
						end else begin
							o_cmd_err <= 1'b1;
						end
					end
				end
				ST_FILL: begin
					o_mem_we    <= 1'b1;
					o_mem_addr  <= addr_reg;
					o_mem_wdata <= data_reg;
					addr_reg    <= addr_reg + {{(AW-1){1'b0}}, 1'b1};
					if (addr_reg == end_reg) begin
						o_busy     <= 1'b0;
						o_cmd_done <= 1'b1;
						state_reg  <= ST_IDLE;
					end
				end
				ST_REQ: begin
					// core runs one instruction, plus any skip it triggers, then halts;
					// the time base is never cleared here, and timers on an external
					// clock keep running between steps, so their state is not assured
					o_core_step <= 1'b1;
					if (abort_hit) begin
						abort_reg <= 1'b1;
					end
					state_reg   <= ST_WAIT;
				end
				ST_WAIT: begin
					if (i_core_done) begin
						// one record per executed instruction, skipped one never reported
						o_rep_valid <= 1'b1;
						o_rep_hdr   <= hdr_due;
						o_rep_addr  <= i_core_exec_addr;
						o_rep_code  <= i_core_exec_code;
						o_rep_cols  <= cols;
						o_rep_show  <= show & cols;
						o_rep_vals  <= i_core_snap;
						hdr_cnt_reg <= (hdr_cnt_reg == `ECS_HDR_EVERY - 4'h1) ? 4'h0
						               : hdr_cnt_reg + 4'h1;
						left_reg    <= left_reg - {{(CNTW-1){1'b0}}, 1'b1};
						if ((left_reg == `ECS_STEP_ONE) | abort_reg | abort_hit) begin
							o_busy              <= 1'b0;
							o_cmd_done          <= 1'b1;
							o_cmd_aborted       <= abort_reg | abort_hit;
							o_core_solo_skip_en <= 1'b0;
							state_reg           <= ST_IDLE;
						end else begin
							state_reg <= ST_REQ;
						end
					end else if (abort_hit) begin
						abort_reg <= 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // ecs_fill_step_ctl

/* ecs_fill_step_properties.sv */
// port assertions for the fill and step command engine
`timescale 1ns/10ps
`include "ecs_map.vh"

module ecs_fill_step_props (
	// clock, reset, mode
	input wire        i_clk,
	input wire        i_srst,
	input wire        i_large_mode,
	// core answer
	input wire        i_core_done,
	input wire [11:0] i_core_exec_addr,
	input wire [15:0] i_core_exec_code,
	// command answer and memory
	input wire        o_cmd_done,
	input wire        o_cmd_err,
	input wire        o_cmd_aborted,
	input wire        o_busy,
	input wire        o_mem_we,
	input wire [11:0] o_mem_addr,
	// core control and report
	input wire        o_core_step,
	input wire        o_core_solo_skip_en,
	input wire        o_rep_valid,
	input wire        o_rep_hdr,
	input wire [11:0] o_rep_addr,
	input wire [15:0] o_rep_code,
	input wire [12:0] o_rep_cols,
	input wire [12:0] o_rep_show
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	a_fill_in_area: assert property (o_mem_we |-> o_mem_addr <= `ECS_DM_HI &&
		o_mem_addr >= (i_large_mode ? `ECS_DM_LO_LARGE : `ECS_DM_LO_SMALL)) else $error("fill outside area");
	a_fill_ascend: assert property (o_mem_we && !o_cmd_done |=>
		o_mem_we && o_mem_addr == $past(o_mem_addr) + 12'h001) else $error("fill not ascending");
	a_err_quiet: assert property (o_cmd_err |-> !o_mem_we && !o_core_step) else $error("refused but acting");
	a_record_copy: assert property (o_busy && i_core_done |=> o_rep_valid &&
		o_rep_addr == $past(i_core_exec_addr) && o_rep_code == $past(i_core_exec_code)) else $error("bad record");
	a_small_no_p4: assert property (o_rep_valid && !i_large_mode |-> o_rep_cols == 13'h17FF)
		else $error("small mode columns");
	a_large_all: assert property (o_rep_valid && i_large_mode |-> o_rep_cols == `ECS_COLS_ALL)
		else $error("large mode columns");
	a_hdr_full: assert property (o_rep_valid && o_rep_hdr |-> o_rep_show == o_rep_cols)
		else $error("header line not full");
	a_show_masked: assert property (o_rep_valid |-> (o_rep_show & ~o_rep_cols) == 13'h0000)
		else $error("shown column absent");
	a_skip_allowed: assert property (o_core_step |-> o_core_solo_skip_en) else $error("solo skip off");
	a_next_step: assert property (o_rep_valid && !o_cmd_done |=> o_core_step) else $error("no next step");

	cover property (o_mem_we && o_cmd_done);
	cover property (o_rep_valid && o_rep_hdr);
	cover property (o_cmd_err);
	cover property (o_cmd_aborted);
endmodule // ecs_fill_step_props

bind ecs_fill_step_ctl ecs_fill_step_props ecs_fill_step_props_i (.i_clk, .i_srst, .i_large_mode,
	.i_core_done, .i_core_exec_addr, .i_core_exec_code, .o_cmd_done, .o_cmd_err, .o_cmd_aborted, .o_busy,
	.o_mem_we, .o_mem_addr, .o_core_step, .o_core_solo_skip_en, .o_rep_valid, .o_rep_hdr, .o_rep_addr,
	.o_rep_code, .o_rep_cols, .o_rep_show);

/* ecs_core_model.sv */
// behavioural emulated core answering single step requests
`timescale 1ns/10ps

module ecs_core_model (
	// clock
	input  wire         i_clk,
	// step request
	input  wire         i_step,
	input  wire         i_set_pc,
	input  wire [11:0]  i_pc,
	// step answer
	output reg          o_done = 1'b0,
	output wire [11:0]  o_addr,
	output wire [15:0]  o_code,
	output wire [103:0] o_snap
);
	reg [11:0] pc_reg = 12'h000;
	reg [11:0] at_reg = 12'h000;
	reg [7:0]  acc_reg = 8'h00;
	reg [3:0]  wait_reg = 4'h0;
	reg [15:0] tbase_reg = 16'h0000;

	// outside the done cycle the lines carry junk, never the last value
	assign o_addr = o_done ? at_reg : ~at_reg;
	assign o_code = o_done ? {4'h0, at_reg} : ~{4'h0, at_reg};
	assign o_snap = o_done ? {88'h0, acc_reg, 8'h00} : ~{88'h0, acc_reg, 8'h00};

	always @(posedge i_clk) begin
		o_done <= 1'b0;
		// free running, never cleared by stepping
		tbase_reg <= tbase_reg + 16'h0001;
		if (i_set_pc)
			pc_reg <= i_pc;
		// odd addresses answer slowly
		if (i_step)
			wait_reg <= pc_reg[0] ? 4'h6 : 4'h1;
		else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
			if (wait_reg == 4'h1) begin
				o_done <= 1'b1;
				at_reg <= pc_reg;
				acc_reg <= acc_reg + 8'h01;
				// a met skip passes the next word inside this step
				pc_reg <= pc_reg + (pc_reg[2] ? 12'h002 : 12'h001);
			end
		end
	end
endmodule // ecs_core_model

/* ecs_fill_step_ctl_test.sv */
// self-checking bench for the fill and step command engine
`timescale 1ns/10ps

module ecs_fill_step_ctl_test;
	reg          i_clk = 1'b0, i_srst = 1'b1, i_large_mode = 1'b1, i_cmd_valid = 1'b0;
	reg          i_cmd_fill = 1'b0, i_cmd_step = 1'b0, i_cmd_wild = 1'b0, i_cmd_addr_given = 1'b0;
	reg          i_cmd_data_given = 1'b0, i_cmd_count_given = 1'b0, i_abort_key = 1'b0, i_core_halt = 1'b0;
	reg  [11:0]  i_cmd_addr_a = 12'h000, i_cmd_addr_b = 12'h000;
	reg  [3:0]   i_cmd_data = 4'h0, wd_exp = 4'h0;
	reg  [15:0]  i_cmd_count = 16'h0000;
	wire         o_busy, o_cmd_done, o_cmd_err, o_cmd_aborted, o_mem_we, o_core_step, o_core_set_pc;
	wire         o_core_solo_skip_en, o_rep_valid, o_rep_hdr, i_core_done;
	wire [11:0]  o_mem_addr, o_core_pc, o_rep_addr, i_core_exec_addr;
	wire [3:0]   o_mem_wdata;
	wire [15:0]  o_rep_code, i_core_exec_code;
	wire [12:0]  o_rep_cols, o_rep_show;
	wire [103:0] o_rep_vals, i_core_snap;
	integer      nwr, nrec, nhdr, nbad, nset, got_err, got_ab, mismatches = 0, samples_checked = 0;
	reg  [11:0]  wa0, wa1, ra0, pa;

	ecs_fill_step_ctl ecs_fill_step_ctl_i (.i_clk, .i_srst, .i_large_mode, .i_cmd_valid, .i_cmd_fill,
		.i_cmd_step, .i_cmd_wild, .i_cmd_addr_given, .i_cmd_addr_a, .i_cmd_addr_b, .i_cmd_data_given,
		.i_cmd_data, .i_cmd_count_given, .i_cmd_count, .i_abort_key, .o_busy, .o_cmd_done, .o_cmd_err,
		.o_cmd_aborted, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_core_step, .o_core_set_pc, .o_core_pc,
		.o_core_solo_skip_en, .i_core_done, .i_core_halt, .i_core_exec_addr, .i_core_exec_code,
		.i_core_snap, .o_rep_valid, .o_rep_hdr, .o_rep_addr, .o_rep_code, .o_rep_cols, .o_rep_show,
		.o_rep_vals);
	ecs_core_model ecs_core_model_i (.i_clk(i_clk), .i_step(o_core_step), .i_set_pc(o_core_set_pc),
		.i_pc(o_core_pc), .o_done(i_core_done), .o_addr(i_core_exec_addr), .o_code(i_core_exec_code),
		.o_snap(i_core_snap));

	always #2.5 i_clk = ~i_clk;

	// ------
	// monitor: writes and step records
	// ------
	always @(posedge i_clk) begin
		if (o_mem_we === 1'b1) begin
			if (nwr == 0)
				wa0 = o_mem_addr;
			wa1 = o_mem_addr;
			if (o_mem_wdata !== wd_exp)
				nbad = nbad + 1;
			nwr = nwr + 1;
		end
		if (o_core_set_pc === 1'b1)
			nset = nset + 1;
		if (o_rep_valid === 1'b1) begin
			if (nrec == 0)
				ra0 = o_rep_addr;
			if (o_rep_hdr === 1'b1)
				nhdr = nhdr + 1;
			// only the accumulator moves in the core model snapshot
			if (o_rep_hdr !== (nrec % 10 == 0) || (o_rep_hdr === 1'b0 && o_rep_show !== 13'h0002))
				nbad = nbad + 1;
			// record copies the core answer and keeps mode columns; a met skip passes one word
			if (o_rep_code !== {4'h0, o_rep_addr} || o_rep_vals[103:16] !== 88'h0 ||
				o_rep_vals[7:0] !== 8'h00 || o_rep_cols !== (i_large_mode ? 13'h1FFF : 13'h17FF))
				nbad = nbad + 1;
			if (nrec > 0 && o_rep_addr !== pa + (pa[2] ? 12'h002 : 12'h001))
				nbad = nbad + 1;
			pa = o_rep_addr;
			nrec = nrec + 1;
		end
	end

	// ------
	// shared tasks
	// ------
	task wrap_up;
		begin
			$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
			if (mismatches == 0 && samples_checked > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	task check(input [8*10-1:0] what, input integer exp, input integer got);
		begin
			samples_checked = samples_checked + 1;
			if (exp !== got) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED %0s expected %0d seen %0d", what, exp, got);
			end
		end
	endtask

	task cmd(input fill, wild, ag, input [11:0] a, b, input dg, input [3:0] d, input cg, input [15:0] cnt,
		input integer ab_at);
		integer k;
		begin
			nwr = 0; nrec = 0; nhdr = 0; nbad = 0; nset = 0;
			{i_cmd_fill, i_cmd_step, i_cmd_wild, i_cmd_addr_given} = {fill, !fill, wild, ag};
			{i_cmd_addr_a, i_cmd_addr_b, i_cmd_data_given, i_cmd_data} = {a, b, dg, d};
			{i_cmd_count_given, i_cmd_count} = {cg, cnt};
			wd_exp = dg ? d : 4'h0;
			i_cmd_valid = 1'b1;
			@(negedge i_clk);
			i_cmd_valid = 1'b0;
			for (k = 0; k < 4000 && !(o_cmd_done || o_cmd_err); k = k + 1) begin
				i_abort_key = ab_at > 0 && nrec >= ab_at;
				@(negedge i_clk);
			end
			got_err = o_cmd_err;
			got_ab = o_cmd_aborted;
			i_abort_key = 1'b0;
			if (k == 4000) begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED wait expected end seen none");
				wrap_up;
			end
			@(negedge i_clk);
		end
	endtask

	// ------
	// scenarios
	// ------
	task t_fill;
		begin
			cmd(1, 0, 0, 12'h07FE, 12'h07FF, 1, 4'hA, 0, 16'h0000, 0);
			check("pair_n", 2, nwr);
			check("pair_a", 12'h07FE, wa0);
			check("pair_d", 0, nbad);
			cmd(1, 1, 0, 12'h0000, 12'h0000, 0, 4'h7, 0, 16'h0000, 0);
			check("wild_n", 256, nwr);
			check("wild_a", 12'h0700, wa0);
			check("wild_d", 0, nbad);
			$display("fill done");
		end
	endtask

	task t_fill_small;
		begin
			i_large_mode = 1'b0;
			cmd(1, 1, 0, 12'h0000, 12'h0000, 1, 4'h5, 0, 16'h0000, 0);
			check("small_n", 128, nwr);
			check("small_a", 12'h0780, wa0);
			check("small_z", 12'h07FF, wa1);
			cmd(1, 0, 0, 12'h077F, 12'h0790, 1, 4'h5, 0, 16'h0000, 0);
			check("low_err", 1, got_err);
			check("low_n", 0, nwr);
			i_large_mode = 1'b1;
			cmd(1, 0, 0, 12'h07A0, 12'h0790, 0, 4'h0, 0, 16'h0000, 0);
			check("rev_err", 1, got_err);
			$display("fill refusal done");
		end
	endtask

	task t_step;
		begin
			cmd(0, 0, 0, 12'h0000, 12'h0000, 0, 4'h0, 0, 16'h0000, 0);
			check("one_n", 1, nrec);
			check("one_pc", 0, nset);
			cmd(0, 0, 1, 12'h0FDF, 12'h0000, 0, 4'h0, 1, 16'h000C, 0);
			check("cnt_n", 12, nrec);
			check("hdr_n", 2, nhdr);
			check("start", 12'h0FDF, ra0);
			check("show", 0, nbad);
			cmd(0, 0, 0, 12'h0000, 12'h0000, 0, 4'h0, 1, 16'h0000, 0);
			check("zero_err", 1, got_err);
			$display("step done");
		end
	endtask

	task t_step_small;
		begin
			i_large_mode = 1'b0;
			cmd(0, 0, 1, 12'h07DF, 12'h0000, 0, 4'h0, 1, 16'h0002, 0);
			check("sm_n", 2, nrec);
			check("sm_rec", 0, nbad);
			cmd(0, 0, 1, 12'h07E0, 12'h0000, 0, 4'h0, 1, 16'h0002, 0);
			check("sm_err", 1, got_err);
			i_large_mode = 1'b1;
			$display("small step done");
		end
	endtask

	task t_abort;
		begin
			cmd(0, 1, 0, 12'h0000, 12'h0000, 0, 4'h0, 0, 16'h0000, 3);
			check("ab_flag", 1, got_ab);
			check("ab_n", 4, nrec);
			check("ab_rec", 0, nbad);
			i_core_halt = 1'b1;
			cmd(0, 0, 0, 12'h0000, 12'h0000, 0, 4'h0, 1, 16'h0003, 1);
			check("halt_ab", 0, got_ab);
			check("halt_n", 3, nrec);
			i_core_halt = 1'b0;
			$display("abort done");
		end
	endtask

	initial begin
		repeat (10) @(negedge i_clk);
		i_srst = 1'b0;
		@(negedge i_clk);
		t_fill;
		t_fill_small;
		t_step;
		t_step_small;
		t_abort;
		wrap_up;
	end
endmodule // ecs_fill_step_ctl_test
